// *** hw/sbc_event_defines.svh ***
// Register offsets, field positions, reset values and timing counts.
// Function
// - Set primary undervoltage flag, supply bit 0, below 90 % while active.
// - Never capture primary undervoltage in Sleep mode.
// - Primary undervoltage capture ignores the reset threshold selection.
// - Set supply bit 2 on secondary or external overvoltage.
// - Set supply bit 1 on secondary or external undervoltage; 7:3 reserved.
// - Set transceiver bit 5 on selective frame detection error.
// - Set bus silence flag, transceiver bit 4, after silence timeout.
// - Detect silence only when enabled and bus was active before.
// - Set bus failure bit 1 on supply loss in mode 01 or clamp, except in Sleep mode.
// - Set bus wake-up bit 0 on bus wake while transceiver offline.
// - Set wake bit 1 on rising wake pin edge.
// - Set wake bit 0 on falling wake pin edge; 7:2 reserved.
// - System enable register: bit 2 overtemp, bit 1 serial failure.
// - Writing 1 clears a status flag; writing 0 leaves it.
// - Global status shows pending per group: wake, transceiver, supply, system.
// - Sleep command with any pending event goes to Reset mode instead.
`ifndef SBC_EVENT_DEFINES_SVH
`define SBC_EVENT_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_SYS_CAP_EN      7'h04
`define ADDR_GLOBAL_STAT     7'h60
`define ADDR_SUPPLY_STAT     7'h62
`define ADDR_TRX_STAT        7'h63
`define ADDR_WAKE_STAT       7'h64

// ****************************************************************
// Field positions and masks
// ****************************************************************
`define SUP_V1_UNDER         0
`define SUP_SEC_UNDER        1
`define SUP_SEC_OVER         2
`define TRX_WAKE             0
`define TRX_FAIL             1
`define TRX_SILENCE          4
`define TRX_FRAME_ERR        5
`define WAKE_FALL            0
`define WAKE_RISE            1
`define SYS_SERIAL_FAIL_EN   1
`define SYS_OVERTEMP_EN      2
`define GRP_SYSTEM           0
`define GRP_SUPPLY           1
`define GRP_TRX              2
`define GRP_WAKE             3
`define MASK_SUPPLY          8'h07
`define MASK_TRX             8'h33
`define MASK_WAKE            8'h03
`define MASK_SYS_CAP_EN      8'h06
`define MASK_GLOBAL          8'h0F
`define TRX_MODE_SUPPLY_OFF  2'h1

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RST_STATUS           8'h00
`define RST_SYS_CAP_EN       8'h06
`define CLK_PERIOD_NS        4
`define SILENCE_TIME_US      1000
`define SILENCE_CYCLES       ((`SILENCE_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// *** hw/sbc_event_pkg.sv ***
// Types shared by the event status capture logic.
package sbc_event_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [6:0] reg_addr_t;
    typedef logic [1:0] trx_mode_t;
    typedef enum logic [1:0] {
        DEC_SLEEP = 2'b01,
        DEC_RESET = 2'b10
    } sleep_decision_t;
endpackage : sbc_event_pkg

// *** hw/bus_silence_timer.sv ***
// Bus silence timeout detector.
`timescale 1ns/100ps
module bus_silence_timer #(
    parameter int unsigned LIMIT = 250000
) (
    input  wire logic clk,
    input  wire logic rstN,
    input  wire logic enable,
    input  wire logic busActivity,
    output logic      silenceEvt
);
    logic [31:0] cnt_ff;
    logic        armed_ff;
    logic        evt_ff;
    wire         atLimit = (cnt_ff == 32'(LIMIT - 1));
    wire         fire    = armed_ff && enable && !busActivity && atLimit;

    // A silent bus is only reported after it has been seen active.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt_ff   <= 32'h0;
            armed_ff <= 1'b0;
            evt_ff   <= 1'b0;
        end else begin
            if (!enable || busActivity)
                cnt_ff <= 32'h0;
            else if (armed_ff && !atLimit)
                cnt_ff <= cnt_ff + 32'h1;
            if (!enable || fire)
                armed_ff <= 1'b0;
            else if (busActivity)
                armed_ff <= 1'b1;
            evt_ff <= fire;
        end
    end

    assign silenceEvt = evt_ff;
endmodule : bus_silence_timer

// *** hw/sbc_event_status_capture.sv ***
// Event status flags, system capture enables and sleep admission.
`timescale 1ns/100ps
`include "sbc_event_defines.svh"
module sbc_event_status_capture
    import sbc_event_pkg::*;
#(
    parameter int unsigned SILENCE_CYCLES = `SILENCE_CYCLES
) (
    input  wire logic      clk,
    input  wire logic      nrst,
    input  wire logic      regWrEn,
    input  wire logic      regRdEn,
    input  wire reg_addr_t regAddr,
    input  wire reg_byte_t regWrData,
    output reg_byte_t      regRdData,
    input  wire logic      sleepMode,
    input  wire logic      primaryUnder,
    input  wire logic      secondaryOver,
    input  wire logic      secondaryUnder,
    input  wire logic [2:0] supplyCaptureEn,
    input  wire logic      frameError,
    input  wire logic      busActivity,
    input  wire trx_mode_t transceiverMode,
    input  wire logic      trxSupplyLoss,
    input  wire logic      txdClamped,
    input  wire logic      busWake,
    input  wire logic      trxOffline,
    input  wire logic      busSilenceDetectEnable,
    input  wire logic      busFailEnable,
    input  wire logic      busWakeEnable,
    input  wire logic      wakePin,
    input  wire logic [1:0] wakeCaptureEn,
    input  wire logic      systemEventPending,
    input  wire logic      sleepCmd,
    output logic           overtempWarningEnable,
    output logic           serialFailureEnable,
    output logic [3:0]     groupPending,
    output logic           enterSleep,
    output logic           enterReset
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rstSync_ff;
    wire        rstN = rstSync_ff[1];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rstSync_ff <= 2'b00;
        else
            rstSync_ff <= {rstSync_ff[0], 1'b1};
    end

    // ****************************************************************
    // Event detection
    // ****************************************************************
    reg_byte_t  supply_ff, trx_ff, wake_ff, sysEn_ff, rdData_ff;
    logic [3:0] group_ff;
    logic       wakePrev_ff, sleep_ff, reset_ff;
    logic       silenceEvt;

    bus_silence_timer #(.LIMIT(SILENCE_CYCLES)) silenceTimer (
        .clk        (clk),
        .rstN       (rstN),
        .enable     (busSilenceDetectEnable),
        .busActivity(busActivity),
        .silenceEvt (silenceEvt)
    );

    // The threshold selection bits are deliberately not an input here.
    wire v1Set   = primaryUnder && !sleepMode
                   && supplyCaptureEn[0];
    wire ovSet   = secondaryOver && supplyCaptureEn[2];
    wire uvSet   = secondaryUnder && supplyCaptureEn[1];
    wire failSrc = (transceiverMode == `TRX_MODE_SUPPLY_OFF
                   && trxSupplyLoss) || txdClamped;
    wire failSet = failSrc && !sleepMode && busFailEnable;
    wire cwSet   = busWake && trxOffline && busWakeEnable;
    wire riseSet = wakePin && !wakePrev_ff && wakeCaptureEn[1];
    wire fallSet = !wakePin && wakePrev_ff && wakeCaptureEn[0];

    wire reg_byte_t supplySet = {5'h00, ovSet, uvSet, v1Set};
    wire reg_byte_t trxSet    = {2'h0, frameError, silenceEvt,
                                 2'h0, failSet, cwSet};
    wire reg_byte_t wakeSet   = {6'h00, riseSet, fallSet};

    // ****************************************************************
    // Register access
    // ****************************************************************
    wire wrSup  = regWrEn && regAddr == `ADDR_SUPPLY_STAT;
    wire wrTrx  = regWrEn && regAddr == `ADDR_TRX_STAT;
    wire wrWake = regWrEn && regAddr == `ADDR_WAKE_STAT;
    wire wrSys  = regWrEn && regAddr == `ADDR_SYS_CAP_EN;

    // A set in the same cycle as its clear wins, so no event is lost.
    function automatic reg_byte_t w1cNext(input reg_byte_t cur,
                                          input reg_byte_t set,
                                          input logic      wr,
                                          input reg_byte_t data,
                                          input reg_byte_t mask);
        reg_byte_t clr;
        clr = wr ? data : 8'h00;
        return ((cur & ~clr) | set) & mask;
    endfunction : w1cNext

    wire reg_byte_t nxt_supply = w1cNext(supply_ff, supplySet, wrSup,
                                         regWrData, `MASK_SUPPLY);
    wire reg_byte_t nxt_trx    = w1cNext(trx_ff, trxSet, wrTrx,
                                         regWrData, `MASK_TRX);
    wire reg_byte_t nxt_wake   = w1cNext(wake_ff, wakeSet, wrWake,
                                         regWrData, `MASK_WAKE);
    wire reg_byte_t nxt_sysEn  = wrSys ? (regWrData & `MASK_SYS_CAP_EN)
                                       : sysEn_ff;
    wire logic [3:0] nxt_group = {|nxt_wake, |nxt_trx, |nxt_supply,
                                  systemEventPending};
    wire reg_byte_t rdMux =
        (regAddr == `ADDR_SUPPLY_STAT) ? supply_ff :
        (regAddr == `ADDR_TRX_STAT)    ? trx_ff :
        (regAddr == `ADDR_WAKE_STAT)   ? wake_ff :
        (regAddr == `ADDR_SYS_CAP_EN)  ? sysEn_ff :
        (regAddr == `ADDR_GLOBAL_STAT) ? {4'h0, group_ff} : 8'h00;

    // Pending uses live flags so a same-cycle event still blocks Sleep.
    wire             anyPending   = (|group_ff) || systemEventPending
                                    || (|supplySet) || (|trxSet)
                                    || (|wakeSet);
    sleep_decision_t decision;
    assign decision = anyPending ? DEC_RESET : DEC_SLEEP;

    // ****************************************************************
    // State
    // ****************************************************************
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            supply_ff   <= `RST_STATUS;
            trx_ff      <= `RST_STATUS;
            wake_ff     <= `RST_STATUS;
            sysEn_ff    <= `RST_SYS_CAP_EN;
            group_ff    <= 4'h0;
            rdData_ff   <= 8'h00;
            wakePrev_ff <= 1'b0;
            sleep_ff    <= 1'b0;
            reset_ff    <= 1'b0;
        end else begin
            supply_ff   <= nxt_supply;
            trx_ff      <= nxt_trx;
            wake_ff     <= nxt_wake;
            sysEn_ff    <= nxt_sysEn;
            group_ff    <= nxt_group;
            wakePrev_ff <= wakePin;
            if (regRdEn)
                rdData_ff <= rdMux;
            case (decision)
                DEC_SLEEP: begin
                    sleep_ff <= sleepCmd;
                    reset_ff <= 1'b0;
                end
                DEC_RESET: begin
                    sleep_ff <= 1'b0;
                    reset_ff <= sleepCmd;
                end
                default: begin
                    sleep_ff <= 1'b0;
                    reset_ff <= sleepCmd;
                end
            endcase
        end
    end

    assign regRdData             = rdData_ff;
    assign overtempWarningEnable = sysEn_ff[`SYS_OVERTEMP_EN];
    assign serialFailureEnable   = sysEn_ff[`SYS_SERIAL_FAIL_EN];
    assign groupPending          = group_ff;
    assign enterSleep            = sleep_ff;
    assign enterReset            = reset_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    AST_V1_SET: assert property (
        primaryUnder && !sleepMode && supplyCaptureEn[0]
        |=> supply_ff[`SUP_V1_UNDER])
        else $error("Primary undervoltage not captured.");
    AST_V1_SLEEP: assert property (
        sleepMode && !supply_ff[`SUP_V1_UNDER]
        |=> !supply_ff[`SUP_V1_UNDER])
        else $error("Primary undervoltage captured in Sleep.");
    AST_SEC_OVER: assert property (
        secondaryOver && supplyCaptureEn[2]
        |=> supply_ff[`SUP_SEC_OVER])
        else $error("Secondary overvoltage not captured.");
    AST_SEC_UNDER: assert property (
        secondaryUnder && supplyCaptureEn[1]
        |=> supply_ff[`SUP_SEC_UNDER] && supply_ff[7:3] == 5'h00)
        else $error("Secondary undervoltage not captured.");
    AST_FAIL_SLEEP: assert property (
        sleepMode && !trx_ff[`TRX_FAIL] |=> !trx_ff[`TRX_FAIL])
        else $error("Bus failure captured in Sleep.");
    AST_WAKE_RISE: assert property (
        wakePin && !$past(wakePin) && wakeCaptureEn[1]
        |=> wake_ff[`WAKE_RISE])
        else $error("Wake rising edge not captured.");
    AST_CLEAR: assert property (
        wrWake && regWrData[`WAKE_FALL] && !fallSet
        |=> !wake_ff[`WAKE_FALL])
        else $error("Write one did not clear flag.");
    AST_HOLD: assert property (
        trx_ff[`TRX_WAKE] && !(wrTrx && regWrData[`TRX_WAKE])
        |=> trx_ff[`TRX_WAKE])
        else $error("Flag dropped without clear.");
    AST_GROUP: assert property (
        group_ff[3:1] == {|wake_ff, |trx_ff, |supply_ff})
        else $error("Group pending does not follow status.");
    AST_SLEEP_BLOCK: assert property (
        sleepCmd && (|group_ff) |=> enterReset && !enterSleep)
        else $error("Sleep admitted with pending event.");
endmodule : sbc_event_status_capture

// *** test/reg_host.sv ***
// Host side model that issues register writes and reads.
`timescale 1ns/100ps
module reg_host
    import sbc_event_pkg::*;
(
    input  wire logic clk,
    output logic      regWrEn,
    output logic      regRdEn,
    output reg_addr_t regAddr,
    output reg_byte_t regWrData
);
    initial begin
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
        regAddr   = 7'h7F;
        regWrData = 8'h00;
    end

    // A released address or data bus shows the inverse, never a stale value.
    task automatic wr(input reg_addr_t a, input reg_byte_t d);
        @(negedge clk);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(negedge clk);
        regWrEn   = 1'b0;
        regAddr   = ~a;
        regWrData = ~d;
    endtask : wr

    task automatic rd(input reg_addr_t a);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        regAddr = ~a;
    endtask : rd
endmodule : reg_host

// *** test/testbench.sv ***
// Self-checking bench for the event status capture block.
`timescale 1ns/100ps
module testbench
    import sbc_event_pkg::*;
;
    localparam int SIL = 20;
    logic clk, nrst, sleepMode, busActivity, trxOffline, sleepCmd, rdDone;
    logic busSilenceDetectEnable, systemEventPending;
    logic [1:0] wakeCaptureEn;
    logic [2:0] supplyCaptureEn;
    logic busFailEnable, busWakeEnable;
    logic [7:0] src;
    trx_mode_t transceiverMode;
    logic regWrEn, regRdEn, otwEn, spifEn, enterSleep, enterReset;
    reg_addr_t regAddr;
    reg_byte_t regWrData, regRdData, expQ[$];
    logic [3:0] groupPending;
    int nErrors, checkCount, cycles;

    reg_host host (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
                   .regAddr(regAddr), .regWrData(regWrData));

    sbc_event_status_capture #(.SILENCE_CYCLES(SIL)) dut (
        .clk(clk), .nrst(nrst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .sleepMode(sleepMode), .primaryUnder(src[0]),
        .secondaryUnder(src[1]), .secondaryOver(src[2]),
        .supplyCaptureEn(supplyCaptureEn), .frameError(src[3]),
        .busActivity(busActivity), .transceiverMode(transceiverMode),
        .trxSupplyLoss(src[4]), .txdClamped(src[5]), .busWake(src[6]),
        .trxOffline(trxOffline),
        .busSilenceDetectEnable(busSilenceDetectEnable),
        .busFailEnable(busFailEnable), .busWakeEnable(busWakeEnable),
        .wakePin(src[7]),
        .wakeCaptureEn(wakeCaptureEn),
        .systemEventPending(systemEventPending), .sleepCmd(sleepCmd),
        .overtempWarningEnable(otwEn), .serialFailureEnable(spifEn),
        .groupPending(groupPending), .enterSleep(enterSleep),
        .enterReset(enterReset));

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input reg_byte_t seen, input reg_byte_t exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stopTest();
        $display("Comparisons %0d, mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stopTest

    // Read data is only valid one edge after the strobe, so compare then.
    always @(posedge clk) rdDone <= regRdEn;
    always @(negedge clk) if (rdDone && expQ.size() > 0) begin
        check(regRdData, expQ.pop_front());
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            nErrors++;
            stopTest();
        end
    end

    task automatic rdx(input reg_addr_t a, input reg_byte_t e);
        expQ.push_back(e);
        host.rd(a);
    endtask : rdx

    // Pulse one source under the given conditions, then test hold and clear.
    task automatic evt(input int i, input logic slp, input trx_mode_t md,
                       input logic off, input logic [1:0] wen,
                       input reg_addr_t a, input reg_byte_t e);
        @(negedge clk);
        sleepMode       = slp;
        transceiverMode = md;
        trxOffline      = off;
        wakeCaptureEn   = wen;
        src[i]          = 1'b1;
        @(negedge clk);
        src[i]          = 1'b0;
        @(negedge clk);
        sleepMode       = 1'b0;
        host.wr(a, reg_byte_t'($urandom) & ~e);
        rdx(a, e);
        check(8'(groupPending[2'(a - 7'h61)]), 8'(e != 8'h00));
        host.wr(a, 8'hFF);
        rdx(a, 8'h00);
    endtask : evt

    task automatic sleepTry(input logic expRst);
        @(negedge clk);
        sleepCmd = 1'b1;
        @(negedge clk);
        sleepCmd = 1'b0;
        check({6'h0, enterReset, enterSleep}, {6'h0, expRst, ~expRst});
    endtask : sleepTry

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        reg_byte_t r;
        {nrst, sleepMode, busActivity, trxOffline, sleepCmd} = '0;
        {busSilenceDetectEnable, systemEventPending, src} = 10'h200;
        supplyCaptureEn = 3'h7;
        {busFailEnable, busWakeEnable} = 2'h3;
        wakeCaptureEn   = 2'h3;
        transceiverMode = 2'h0;
        void'($urandom(88));
        repeat (5) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        repeat (3) @(posedge clk);
        rdx(7'h04, 8'h06);
        rdx(7'h62, 8'h00);
        rdx(7'h10, 8'h00);
        r = reg_byte_t'($urandom);
        host.wr(7'h04, r);
        rdx(7'h04, r & 8'h06);
        check({6'h0, otwEn, spifEn}, {6'h0, r[2], r[1]});
        host.wr(7'h04, 8'h06);
        @(negedge clk) busSilenceDetectEnable = 1'b0;
        busActivity = 1'b1;
        @(negedge clk) busActivity = 1'b0;
        repeat (SIL + 10) @(negedge clk);
        rdx(7'h63, 8'h00);
        busSilenceDetectEnable = 1'b1;
        repeat (SIL + 10) @(negedge clk);
        rdx(7'h63, 8'h00);
        @(negedge clk) busActivity = 1'b1;
        @(negedge clk) busActivity = 1'b0;
        repeat (SIL + 10) @(negedge clk);
        rdx(7'h63, 8'h10);
        host.wr(7'h63, 8'hFF);
        rdx(7'h63, 8'h00);
        evt(0, 1'b0, 2'h0, 1'b0, 2'h3, 7'h62, 8'h01);
        evt(0, 1'b1, 2'h0, 1'b0, 2'h3, 7'h62, 8'h00);
        evt(1, 1'b0, 2'h0, 1'b0, 2'h3, 7'h62, 8'h02);
        evt(2, 1'b0, 2'h0, 1'b0, 2'h3, 7'h62, 8'h04);
        evt(3, 1'b0, 2'h0, 1'b0, 2'h3, 7'h63, 8'h20);
        evt(4, 1'b0, 2'h1, 1'b0, 2'h3, 7'h63, 8'h02);
        evt(4, 1'b0, 2'h2, 1'b0, 2'h3, 7'h63, 8'h00);
        evt(4, 1'b1, 2'h1, 1'b0, 2'h3, 7'h63, 8'h00);
        evt(5, 1'b0, 2'h0, 1'b0, 2'h3, 7'h63, 8'h02);
        evt(6, 1'b0, 2'h0, 1'b1, 2'h3, 7'h63, 8'h01);
        evt(6, 1'b0, 2'h0, 1'b0, 2'h3, 7'h63, 8'h00);
        evt(7, 1'b0, 2'h0, 1'b0, 2'h2, 7'h64, 8'h02);
        evt(7, 1'b0, 2'h0, 1'b0, 2'h1, 7'h64, 8'h01);
        evt(7, 1'b0, 2'h0, 1'b0, 2'h0, 7'h64, 8'h00);
        supplyCaptureEn = 3'($urandom);
        {busFailEnable, busWakeEnable} = 2'($urandom);
        transceiverMode = 2'h1;
        trxOffline      = 1'b1;
        @(negedge clk) src = 8'h57;
        @(negedge clk) src = 8'h00;
        rdx(7'h62, {5'h00, supplyCaptureEn});
        rdx(7'h63, {6'h00, busFailEnable, busWakeEnable});
        host.wr(7'h62, 8'hFF);
        host.wr(7'h63, 8'hFF);
        supplyCaptureEn = 3'h7;
        {busFailEnable, busWakeEnable} = 2'h3;
        @(negedge clk) src[3] = 1'b1;
        @(negedge clk) src[3] = 1'b0;
        sleepTry(1'b1);
        host.wr(7'h63, 8'hFF);
        repeat (3) @(negedge clk);
        sleepTry(1'b0);
        @(negedge clk) systemEventPending = 1'b1;
        @(negedge clk);
        check(8'(groupPending[0]), 8'h01);
        rdx(7'h60, 8'h01);
        sleepTry(1'b1);
        systemEventPending = 1'b0;
        repeat (3) @(negedge clk);
        stopTest();
    end
endmodule : testbench
